/* sie_pkg.sv */
`default_nettype none
package sie_pkg;
   // Width of the instruction address bus.
   localparam int unsigned ADDR_W = 8;
   // Width of the program counter stack index.
   localparam int unsigned STACK_IDX_W = 4;
   // Forced address taken on interrupt entry.
   localparam logic [7:0] IRQ_VECTOR = 8'hFF;
   // Address after reset.
   localparam logic [7:0] PC_RESET = 8'h00;
   // Clock cycles per instruction.
   localparam int unsigned CYC_PER_INSTR = 2;
   // Interrupt enable after reset is off.
   localparam logic IE_RESET = 1'b0;
   // Least number of rising edges the source holds its request.
   localparam int unsigned IRQ_HOLD_EDGES = 2;
   // Acknowledge schemes of the interrupt source.
   typedef enum logic [1:0] {
      SIE_ACK_PORT_WRITE,
      SIE_ACK_PORT_READ,
      SIE_ACK_VECTOR
   } sie_ack_mode_t;
   // Instruction phase of the two-cycle cadence.
   typedef enum logic {
      SIE_PH_FETCH,
      SIE_PH_EXEC
   } sie_phase_t;
endpackage
`default_nettype wire

/* sie_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Signals between the processor's exception unit and the interrupt source.
interface sie_link_if;
   logic       irq;          // Interrupt request from the source, active high level.
   logic [7:0] instr_addr;   // Instruction address bus of the processor.
   logic       rd_strobe;    // One-cycle port read pulse.
   logic       wr_strobe;    // One-cycle port write pulse.
   logic [7:0] port_id;      // Port address with the strobes.
   // Processor end drives the bus and strobes, reads the request.
   modport cpu (input irq, output instr_addr, output rd_strobe, output wr_strobe, output port_id);
   // Source end drives the request, watches the bus and strobes.
   modport src (output irq, input instr_addr, input rd_strobe, input wr_strobe, input port_id);
endinterface
`default_nettype wire

/* sie_cpu_exc.sv */
`timescale 1ns/1ps
`default_nettype none
module sie_cpu_exc #(
   parameter int unsigned STACK_DEPTH = 16   // Depth of the cyclic return stack.
) (
   input  wire logic       sys_clk_i,          // System clock.
   input  wire logic       rst_i,              // Asynchronous reset, active high.
   sie_link_if.cpu         link,               // Link to the interrupt source.
   input  wire logic [7:0] instr_addr_next_i,  // Address the core wants next if undisturbed.
   input  wire logic       carry_i,            // Carry result of the executing instruction.
   input  wire logic       zero_i,             // Zero result of the executing instruction.
   input  wire logic       flags_we_i,         // Executing instruction updates the flags.
   input  wire logic       en_irq_i,           // Executing instruction enables interrupts.
   input  wire logic       dis_irq_i,          // Executing instruction disables interrupts.
   input  wire logic       retirq_i,           // Executing instruction is return_from_irq_instr.
   input  wire logic       retirq_en_i,        // Return option: re-enable interrupts.
   input  wire logic       port_rd_i,          // Executing instruction reads a port.
   input  wire logic       port_wr_i,          // Executing instruction writes a port.
   input  wire logic [7:0] port_id_i,          // Port address of the executing instruction.
   output logic            exec_en_o,          // High in the execute cycle of a kept instruction.
   output logic            phase_o,            // High in the second cycle of each instruction.
   output logic            carry_o,            // Carry flag.
   output logic            zero_o,             // Zero flag.
   output logic            irq_en_o,           // Interrupt input enable.
   output logic            irq_taken_o         // One-cycle pulse on interrupt entry.
);
   // Refuses, at elaboration, a stack that the pointer cannot index or that is too shallow to wrap.
   if (STACK_DEPTH < 2 || STACK_DEPTH > (1 << sie_pkg::STACK_IDX_W))
   begin
      $error("STACK_DEPTH out of range");
   end

   sie_pkg::sie_phase_t   phase_q;        // Current cycle within the instruction.
   logic [7:0]            pc_q;           // Driven instruction address.
   logic                  carry_q;        // Live carry flag.
   logic                  zero_q;         // Live zero flag.
   logic                  carry_sv_q;     // Carry preserved at entry.
   logic                  zero_sv_q;      // Zero preserved at entry.
   logic                  ie_q;           // Interrupt enable.
   logic                  irq_q;          // Request sampled at a rising edge.
   logic [sie_pkg::STACK_IDX_W-1:0] sp_q; // Stack pointer, wraps cyclically.
   logic [7:0]            stack_q [STACK_DEPTH]; // Cyclic return address stack.
   logic                  rd_q;           // Registered read strobe.
   logic                  wr_q;           // Registered write strobe.
   logic [7:0]            pid_q;          // Registered port address.

   // Entry is decided in the execute cycle: the fetched instruction at pc_q is dropped.
   wire take_w    = (phase_q == sie_pkg::SIE_PH_EXEC) && irq_q && ie_q;
   wire exec_w    = (phase_q == sie_pkg::SIE_PH_EXEC) && !take_w;
   wire ret_w     = exec_w && retirq_i;
   wire [sie_pkg::STACK_IDX_W-1:0] sp_dec_w = (sp_q == '0) ?
      sie_pkg::STACK_IDX_W'(STACK_DEPTH - 1) : sp_q - 1'b1;
   wire [sie_pkg::STACK_IDX_W-1:0] sp_inc_w = (sp_q == sie_pkg::STACK_IDX_W'(STACK_DEPTH - 1)) ?
      '0 : sp_q + 1'b1;

   // Phase toggles every cycle; entry takes the same two cycles as any instruction.
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         phase_q <= sie_pkg::SIE_PH_FETCH;
      end
      else
      begin
         phase_q <= (phase_q == sie_pkg::SIE_PH_FETCH) ? sie_pkg::SIE_PH_EXEC : sie_pkg::SIE_PH_FETCH;
      end
   end

   // The request is sampled on every rising edge; a short pulse may be missed.
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         irq_q <= 1'b0;
      end
      else
      begin
         irq_q <= link.irq;
      end
   end

   // Program counter moves only at the end of an execute cycle.
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pc_q <= sie_pkg::PC_RESET;
      end
      else if (take_w)
      begin
         pc_q <= sie_pkg::IRQ_VECTOR;
      end
      else if (ret_w)
      begin
         pc_q <= stack_q[sp_dec_w];
      end
      else if (exec_w)
      begin
         pc_q <= instr_addr_next_i;
      end
   end

   // On entry the abandoned address is pushed so that return re-executes it.
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sp_q <= '0;
      end
      else if (take_w)
      begin
         sp_q <= sp_inc_w;
      end
      else if (ret_w)
      begin
         sp_q <= sp_dec_w;
      end
   end

   // Stack storage has no reset; stale entries are simply overwritten.
   always_ff @(posedge sys_clk_i)
   begin
      if (take_w)
      begin
         stack_q[sp_q] <= pc_q;
      end
   end

   // Live flags follow executed instructions and are restored on return.
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         carry_q <= 1'b0;
         zero_q  <= 1'b0;
      end
      else if (ret_w)
      begin
         carry_q <= carry_sv_q;
         zero_q  <= zero_sv_q;
      end
      else if (exec_w && flags_we_i)
      begin
         carry_q <= carry_i;
         zero_q  <= zero_i;
      end
   end

   // Flags are saved at entry; the dropped instruction never touched them.
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         carry_sv_q <= 1'b0;
         zero_sv_q  <= 1'b0;
      end
      else if (take_w)
      begin
         carry_sv_q <= carry_q;
         zero_sv_q  <= zero_q;
      end
   end

   // Enable starts off, is cleared on entry, and set or cleared by instructions.
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ie_q <= sie_pkg::IE_RESET;
      end
      else if (take_w)
      begin
         ie_q <= 1'b0;
      end
      else if (ret_w)
      begin
         ie_q <= retirq_en_i;
      end
      else if (exec_w && (en_irq_i || dis_irq_i))
      begin
         ie_q <= en_irq_i && !dis_irq_i;
      end
   end

   // Port strobes issued only for executed instructions, registered as data.
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rd_q  <= 1'b0;
         wr_q  <= 1'b0;
         pid_q <= '0;
      end
      else
      begin
         rd_q  <= exec_w && port_rd_i;
         wr_q  <= exec_w && port_wr_i;
         pid_q <= port_id_i;
      end
   end

   // Outputs.
   assign link.instr_addr = pc_q;
   assign link.rd_strobe  = rd_q;
   assign link.wr_strobe  = wr_q;
   assign link.port_id    = pid_q;
   assign exec_en_o       = exec_w;
   assign phase_o         = (phase_q == sie_pkg::SIE_PH_EXEC);
   assign carry_o         = carry_q;
   assign zero_o          = zero_q;
   assign irq_en_o        = ie_q;
   assign irq_taken_o     = take_w;
endmodule
`default_nettype wire

/* sie_irq_src.sv */
`timescale 1ns/1ps
`default_nettype none
// Interrupt source: holds its request until acknowledged.
module sie_irq_src #(
   parameter logic [7:0] ACK_PORT = 8'h00   // Acknowledge port address.
) (
   input  wire logic       sys_clk_i,  // System clock.
   input  wire logic       rst_i,      // Asynchronous reset, active high.
   sie_link_if.src         link,       // Link to the processor.
   input  wire logic       event_i,    // One-cycle event pulse to report.
   input  wire logic [1:0] ack_mode_i, // Acknowledge scheme, see sie_ack_mode_t.
   output logic            pending_o   // Request is pending.
);
   logic irq_q;   // Held request.
   logic fresh_q; // Request was set at the last edge and may not be cleared yet.

   // Port write, port read and vector sighting decodes.
   wire wr_ack_w  = link.wr_strobe && (link.port_id == ACK_PORT);
   wire rd_ack_w  = link.rd_strobe && (link.port_id == ACK_PORT);
   wire vec_ack_w = (link.instr_addr == sie_pkg::IRQ_VECTOR);
   wire ack_w =
      (ack_mode_i == 2'(sie_pkg::SIE_ACK_PORT_WRITE)) ? wr_ack_w :
      (ack_mode_i == 2'(sie_pkg::SIE_ACK_PORT_READ))  ? rd_ack_w : vec_ack_w;
   // A fresh request ignores an acknowledge, so that it is seen at two rising edges at least.
   wire clr_w = ack_w && !fresh_q;

   // Remembers that the request was set at the last edge.
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         fresh_q <= 1'b0;
      end
      else
      begin
         fresh_q <= event_i;
      end
   end

   // Request held until acknowledged, so it spans at least two edges; a new event wins.
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         irq_q <= 1'b0;
      end
      else if (event_i)
      begin
         irq_q <= 1'b1;
      end
      else if (clr_w)
      begin
         irq_q <= 1'b0;
      end
   end

   assign link.irq  = irq_q;
   assign pending_o = irq_q;
endmodule
`default_nettype wire

/* sie_link_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the link and the processor's entry outputs.
module sie_link_chk (
   input  wire logic       sys_clk_i,     // System clock.
   input  wire logic       rst_i,         // Reset, active high.
   input  wire logic       irq_i,         // Request from the source.
   input  wire logic [7:0] instr_addr_i,  // Instruction address.
   input  wire logic       rd_strobe_i,   // Port read pulse.
   input  wire logic       wr_strobe_i,   // Port write pulse.
   input  wire logic       phase_i,       // Execute cycle flag.
   input  wire logic       irq_en_i,      // Interrupt enable.
   input  wire logic       irq_taken_i    // Entry pulse.
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // Entry: the pulse, then the vector with the input switched off.
   sequence s_entry;
      irq_taken_i ##1 (instr_addr_i == sie_pkg::IRQ_VECTOR && !irq_en_i);
   endsequence
   // No port strobe at all.
   sequence s_quiet;
      !rd_strobe_i && !wr_strobe_i;
   endsequence
   a_vector_forced: assert property (irq_taken_i |-> s_entry)
      else $error("vector not forced after entry");
   a_entry_silent: assert property (irq_taken_i |=> s_quiet)
      else $error("abandoned instruction strobed a port");
   a_two_cycle: assert property (1'b1 |=> phase_i != $past(phase_i))
      else $error("cadence broken");
   a_addr_stands: assert property ($changed(instr_addr_i) |-> !phase_i)
      else $error("address changed inside an instruction");
   a_take_cause: assert property (irq_taken_i |-> phase_i && irq_en_i && $past(irq_i))
      else $error("entry without a sampled request");
   a_ignore_off: assert property (!irq_en_i |-> !irq_taken_i)
      else $error("entry while disabled");
   a_enable_timed: assert property ($changed(irq_en_i) |-> !phase_i)
      else $error("enable changed mid instruction");
   a_strobe_slot: assert property ((rd_strobe_i || wr_strobe_i) |-> !phase_i && $past(phase_i))
      else $error("strobe outside its slot");
   a_request_held: assert property ($rose(irq_i) |=> irq_i)
      else $error("request dropped after one edge");
endmodule
`default_nettype wire

/* soft_cpu_interrupt_entry_return_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module soft_cpu_interrupt_entry_return_tb;
   localparam logic [9:0] EN = 10'h040, DS = 10'h020, RT = 10'h010, RE = 10'h008;
   localparam logic [9:0] RD = 10'h004, WR = 10'h002, EV = 10'h001;
   localparam logic [7:0] ACK_PORT = 8'h00;      // Port that the source takes as acknowledge.
   logic sys_clk_i = 1'b0, rst_i = 1'b1;        // Clock and reset.
   logic [7:0] nx = 8'h00, cur = 8'h00;          // Next address input and model address.
   logic fw = 0, cy = 0, zr = 0, en = 0, ds = 0; // Instruction decode inputs.
   logic rt = 0, re = 0, rd = 0, wr = 0, ev = 0; // Further decode inputs and event.
   logic [1:0] md = 2'h0;                        // Acknowledge scheme.
   logic ie = 0, pend = 0, mc = 0, mz = 0;       // Model enable, request and flags.
   logic phase_o, irq_en_o, carry_o, zero_o, irq_taken_o, exec_en_o, pending_o;
   logic [9:0] stk[$];                           // Model return stack.
   logic [10:0] exp_q[$];                        // Expected results in order.
   logic [1:0] act_q[$];                         // Expected execute and entry flags in order.
   logic [7:0] port_sel = 8'h00, port_nx = 8'h00; // Driven port address and the next one.
   int fails = 0, compares = 0, seed = 10296;
   sie_link_if link_if ();
   sie_cpu_exc sie_cpu_exc_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(link_if),
      .instr_addr_next_i(nx), .carry_i(cy), .zero_i(zr), .flags_we_i(fw), .en_irq_i(en),
      .dis_irq_i(ds), .retirq_i(rt), .retirq_en_i(re), .port_rd_i(rd), .port_wr_i(wr),
      .port_id_i(port_sel), .exec_en_o(exec_en_o), .phase_o(phase_o), .carry_o(carry_o),
      .zero_o(zero_o), .irq_en_o(irq_en_o), .irq_taken_o(irq_taken_o));
   sie_irq_src sie_irq_src_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(link_if),
      .event_i(ev), .ack_mode_i(md), .pending_o(pending_o));
   sie_link_chk sie_link_chk_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .irq_i(link_if.irq),
      .instr_addr_i(link_if.instr_addr), .rd_strobe_i(link_if.rd_strobe), .wr_strobe_i(link_if.wr_strobe),
      .phase_i(phase_o), .irq_en_i(irq_en_o), .irq_taken_i(irq_taken_o));
   // Free running clock.
   always #4 sys_clk_i = ~sys_clk_i;
   // Counts and reports one comparison.
   task automatic chk(input logic [10:0] s, input logic [10:0] e);
      compares++;
      if (s !== e)
      begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic report_and_stop;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Runs one two-cycle instruction and notes the state it should leave.
   task automatic ins(input logic [7:0] a, input logic [9:0] c);
      logic tk;
      @(posedge sys_clk_i);
      #1;
      if (phase_o !== 1'b0)
      begin
         @(posedge sys_clk_i);
         #1;
      end
      nx = a;
      port_sel = port_nx;
      {fw, cy, zr, en, ds, rt, re, rd, wr, ev} = c;
      tk = pend & ie;
      if (tk)
      begin
         stk.push_back({mc, mz, cur});
         cur = 8'hFF;
         ie = 1'b0;
         pend = !md[1];
      end
      else if (rt)
      begin
         {mc, mz, cur} = stk.pop_back();
         ie = re;
      end
      else
      begin
         cur = a;
         if (fw)
            {mc, mz} = {cy, zr};
         ie = en | (ie & ~ds);
         if (((wr && md == 2'h0) || (rd && md == 2'h1)) && port_sel == ACK_PORT)
            pend = 1'b0;
      end
      pend = pend | ev;
      @(posedge sys_clk_i);
      #1;
      ev = 1'b0;
      exp_q.push_back({ie, mc, mz, cur});
      act_q.push_back({~tk, tk});
   endtask
   // Random plain instructions that write the flags.
   task automatic fill(input int n);
      repeat (n) ins(8'($random(seed)), {1'b1, 2'($random(seed)), 7'h00});
   endtask
   // Compares each settled result with the oldest note.
   always @(negedge sys_clk_i)
   begin
      if (!rst_i && phase_o === 1'b0 && exp_q.size() > 0)
         chk({irq_en_o, carry_o, zero_o, link_if.instr_addr}, exp_q.pop_front());
   end
   // Compares the execute and entry flags of each execute cycle with the oldest note.
   always @(negedge sys_clk_i)
   begin
      if (!rst_i && phase_o === 1'b1 && act_q.size() > 0)
         chk({9'h000, exec_en_o, irq_taken_o}, {9'h000, act_q.pop_front()});
   end
   // Cuts a hang short.
   initial
   begin
      #20000;
      fails++;
      report_and_stop();
   end
   // Main sequence of scenarios.
   initial
   begin
      repeat (2) @(posedge sys_clk_i);
      #1;
      rst_i = 1'b0;
      fill(3);
      ins(8'h04, EV);
      fill(2);
      ins(8'h05, WR);
      ins(8'h06, EN);
      md = 2'h2;
      ins(8'h07, EV);
      ins(8'h08, 10'h302);
      ins(8'hB0, 10'h280);
      ins(8'h00, RT | RE);
      ins(8'h09, 10'h300);
      md = 2'h0;
      ins(8'h0A, EV);
      ins(8'h0B, WR);
      ins(8'hB0, 10'h000);
      ins(8'h00, RT | RE);
      ins(8'hB0, 10'h000);
      ins(8'hB1, WR);
      ins(8'h00, RT);
      md = 2'h1;
      ins(8'h0C, EV);
      port_nx = 8'h04;
      ins(8'h0D, RD);
      port_nx = ACK_PORT;
      ins(8'h0E, RD);
      chk({10'h000, pending_o}, 11'h001);
      ins(8'h0F, 10'h000);
      chk({10'h000, pending_o}, 11'h000);
      md = 2'h3;
      ins(8'h10, EN);
      ins(8'h11, DS | EV);
      fill(2);
      ins(8'h12, EN);
      fill(4);
      repeat (4) @(posedge sys_clk_i);
      report_and_stop();
   end
endmodule
`default_nettype wire
